/* ssld_pkg.sv */
// package of constants and types for the serial shift latch driver
package ssld_pkg;
    localparam int unsigned SSLD_STAGES = 12;
    localparam int unsigned SSLD_PINS   = 5;

    // bit positions of the pin group passed through the input filter
    localparam int unsigned SSLD_PIN_SHIFT_CLK = 0;
    localparam int unsigned SSLD_PIN_LATCH_CLK = 1;
    localparam int unsigned SSLD_PIN_DATA      = 2;
    localparam int unsigned SSLD_PIN_CLEAR_N   = 3;
    localparam int unsigned SSLD_PIN_OE_N      = 4;

    // idle pin levels: clear released, outputs disabled, clocks low
    localparam logic [SSLD_PINS-1:0] SSLD_PIN_RST = 5'h18;

    localparam logic [SSLD_STAGES-1:0] SSLD_REG_RST  = 12'h000;
    localparam logic                   SSLD_CASC_RST = 1'h0;

    typedef logic [SSLD_STAGES-1:0] ssld_word_t;

    typedef struct packed {
        ssld_word_t shift_q;
        ssld_word_t store_q;
        ssld_word_t buf_q;
        logic       cascade_q;
        logic       sclk_prev_q;
        logic       lclk_prev_q;
    } ssld_state_s;
endpackage

/* ssld_sync.sv */
// three-stage synchroniser with agreement filter for a group of pins
`timescale 1ns/1ps
module ssld_sync
    import ssld_pkg::*;
#(
    parameter int unsigned         W   = SSLD_PINS,
    parameter logic [W-1:0]        RST = SSLD_PIN_RST
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // raw pins and filtered levels
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    typedef struct packed {
        logic [W-1:0] s1_q;
        logic [W-1:0] s2_q;
        logic [W-1:0] s3_q;
        logic [W-1:0] lvl_q;
    } ssld_sync_s;

    ssld_sync_s st_q;
    ssld_sync_s st_d;

    always_comb begin
        st_d      = st_q;
        st_d.s1_q = pin_i;
        st_d.s2_q = st_q.s1_q;
        st_d.s3_q = st_q.s2_q;
        // a change counts only once stages two and three agree
        for (int i = 0; i < W; i++) begin
            if (st_q.s2_q[i] == st_q.s3_q[i]) begin
                st_d.lvl_q[i] = st_q.s3_q[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '{s1_q: RST, s2_q: RST, s3_q: RST, lvl_q: RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign level_o = st_q.lvl_q;
endmodule

/* ssld_top.sv */
// serial shift latch driver: shift register, storage register, sink channels
// Notes on behaviour
// RULE_01: each rising shift clock edge loads the serial input into stage zero
// RULE_02: twelve stages; the last stage feeds the cascade output
// RULE_03: cascade output changes on the falling shift clock edge only; the code also forces it to zero while clear is low
// RULE_04: rising latch clock copies all shift stages into the storage register
// RULE_05: clear low forces shift, storage and output buffer to zero
// RULE_06: storage reaches the output buffer only while clear is high
// RULE_07: output enable low makes each sink follow its storage bit
// RULE_08: output enable high turns all twelve sinks off
// RULE_09: twelve separate open-drain sink channels, zero to eleven
// RULE_10: host chains cascade output to next input, sharing the shift clock
// RULE_11: a sink conducts when its buffer bit is one, else off
// RULE_12: each shift moves every stage up; first bit ends in stage eleven
// RULE_13: clear acts without waiting for a clock and holds until released
`timescale 1ns/1ps
module ssld_top
    import ssld_pkg::*;
#(
    parameter int unsigned N = SSLD_STAGES
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // serial side pins
    input  wire logic         shift_clock_i,
    input  wire logic         latch_clock_i,
    input  wire logic         shift_data_in_i,
    input  wire logic         clear_n_i,
    input  wire logic         output_enable_n_i,
    output logic              cascade_data_out_o,
    // open-drain sink channels, enable high while pulling low
    output logic      [N-1:0] sink_channel_o,
    output logic      [N-1:0] sink_channel_oe_o
);
    logic [SSLD_PINS-1:0] lvl;
    logic                 sclk;
    logic                 lclk;
    logic                 din;
    logic                 clr_n;
    logic                 oe_n;
    logic                 sclk_rise;
    logic                 sclk_fall;
    logic                 lclk_rise;

    ssld_state_s st_q;
    ssld_state_s st_d;

    // rising transition of a filtered level against its value one cycle earlier
    function automatic logic edge_of(input logic now_v, input logic was_v);
        return now_v & ~was_v;
    endfunction

    ssld_sync #(
        .W   (SSLD_PINS),
        .RST (SSLD_PIN_RST)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   ({output_enable_n_i, clear_n_i, shift_data_in_i,
                   latch_clock_i, shift_clock_i}),
        .level_o (lvl)
    );

    assign sclk  = lvl[SSLD_PIN_SHIFT_CLK];
    assign lclk  = lvl[SSLD_PIN_LATCH_CLK];
    assign din   = lvl[SSLD_PIN_DATA];
    assign clr_n = lvl[SSLD_PIN_CLEAR_N];
    assign oe_n  = lvl[SSLD_PIN_OE_N];

    // data and clock take the same filter path, so their skew is preserved
    assign sclk_rise = edge_of(sclk, st_q.sclk_prev_q);
    assign sclk_fall = edge_of(st_q.sclk_prev_q, sclk);
    assign lclk_rise = edge_of(lclk, st_q.lclk_prev_q);

    always_comb begin
        st_d             = st_q;
        st_d.sclk_prev_q = sclk;
        st_d.lclk_prev_q = lclk;
        if (!clr_n) begin
            // clear overrides both clocks and holds for as long as it is low
            st_d.shift_q   = SSLD_REG_RST;                              // [RULE_05] [RULE_13]
            st_d.store_q   = SSLD_REG_RST;                              // [RULE_05]
            st_d.buf_q     = SSLD_REG_RST;                              // [RULE_05]
            st_d.cascade_q = SSLD_CASC_RST;
        end else begin
            if (sclk_rise) begin
                st_d.shift_q = {st_q.shift_q[N-2:0], din};              // [RULE_01] [RULE_12]
            end
            if (sclk_fall) begin
                // half a shift period of hold for the next device in the chain
                st_d.cascade_q = st_q.shift_q[N-1];                     // [RULE_02] [RULE_03]
            end
            if (lclk_rise) begin
                st_d.store_q = st_q.shift_q;                            // [RULE_04]
            end
            st_d.buf_q = oe_n ? SSLD_REG_RST : st_q.store_q;            // [RULE_06] [RULE_07] [RULE_08]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '{shift_q: SSLD_REG_RST, store_q: SSLD_REG_RST, buf_q: SSLD_REG_RST,
                      cascade_q: SSLD_CASC_RST, sclk_prev_q: 1'h0, lclk_prev_q: 1'h0};
        end else begin
            st_q <= st_d;
        end
    end

    assign cascade_data_out_o = st_q.cascade_q;
    // the pins only ever pull low; a set buffer bit turns the sink on
    assign sink_channel_o     = '0;                                     // [RULE_09]
    assign sink_channel_oe_o  = st_q.buf_q;                             // [RULE_11]

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_shift_in;
        sclk_rise && clr_n |=> st_q.shift_q[0] == $past(din);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("serial input not loaded"); // [RULE_01]

    property p_shift_move;
        sclk_rise && clr_n |=> st_q.shift_q[N-1:1] == $past(st_q.shift_q[N-2:0]);
    endproperty
    a_shift_move: assert property (p_shift_move) else $error("stages did not move up"); // [RULE_12]

    property p_cascade_fall;
        sclk_fall && clr_n |=> cascade_data_out_o == $past(st_q.shift_q[N-1]);
    endproperty
    a_cascade_fall: assert property (p_cascade_fall) else $error("cascade not last stage"); // [RULE_02]

    property p_cascade_hold;
        !sclk_fall && clr_n |=> $stable(cascade_data_out_o);
    endproperty
    a_cascade_hold: assert property (p_cascade_hold) else $error("cascade moved off edge"); // [RULE_03]

    property p_latch;
        lclk_rise && clr_n |=> st_q.store_q == $past(st_q.shift_q);
    endproperty
    a_latch: assert property (p_latch) else $error("storage not loaded"); // [RULE_04]

    property p_clear;
        !clr_n [*2] |=> st_q.shift_q == '0 && st_q.store_q == '0 && sink_channel_oe_o == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not empty registers"); // [RULE_05]

    property p_clear_now;
        $fell(clr_n) |=> sink_channel_oe_o == '0 && cascade_data_out_o == 1'h0;
    endproperty
    a_clear_now: assert property (p_clear_now) else $error("clear waited for a clock"); // [RULE_13]

    property p_follow;
        clr_n && !oe_n |=> sink_channel_oe_o == $past(st_q.store_q);
    endproperty
    a_follow: assert property (p_follow) else $error("sinks do not follow storage"); // [RULE_07]

    property p_off;
        oe_n |=> sink_channel_oe_o == '0;
    endproperty
    a_off: assert property (p_off) else $error("sinks on while disabled"); // [RULE_08]

    property p_pass;
        sink_channel_oe_o != '0 |-> $past(clr_n) && sink_channel_o == '0;
    endproperty
    a_pass: assert property (p_pass) else $error("buffer passed while cleared"); // [RULE_06]

    // the shift and storage registers and the cascade output hold still between edges, and clear beats both clocks
    property p_shift_idle;
        clr_n && !sclk_rise |=> $stable(st_q.shift_q);
    endproperty
    a_shift_idle: assert property (p_shift_idle) else $error("shift moved without edge"); // [RULE_01]

    property p_shift_last;
        sclk_rise && clr_n |=> st_q.shift_q[N-1] == $past(st_q.shift_q[N-2]);
    endproperty
    a_shift_last: assert property (p_shift_last) else $error("last stage not fed"); // [RULE_02]

    property p_store_idle;
        clr_n && !lclk_rise |=> $stable(st_q.store_q);
    endproperty
    a_store_idle: assert property (p_store_idle) else $error("storage moved without edge"); // [RULE_04]

    property p_casc_rise;
        sclk_rise && clr_n |=> $stable(cascade_data_out_o);
    endproperty
    a_casc_rise: assert property (p_casc_rise) else $error("cascade moved on rise"); // [RULE_03]

    property p_casc_change;
        $changed(cascade_data_out_o) |-> $past(sclk_fall) || !$past(clr_n);
    endproperty
    a_casc_change: assert property (p_casc_change) else $error("cascade changed off fall"); // [RULE_03]

    property p_clear_buf;
        !clr_n |=> sink_channel_oe_o == '0;
    endproperty
    a_clear_buf: assert property (p_clear_buf) else $error("buffer kept while cleared"); // [RULE_05]

    property p_clear_casc;
        !clr_n |=> cascade_data_out_o == 1'h0;
    endproperty
    a_clear_casc: assert property (p_clear_casc) else $error("cascade kept while cleared"); // [RULE_05]

    property p_clear_shift_blocked;
        !clr_n && sclk_rise |=> st_q.shift_q == '0;
    endproperty
    a_clear_shift_blocked: assert property (p_clear_shift_blocked) else $error("shift during clear"); // [RULE_13]

    property p_clear_latch_blocked;
        !clr_n && lclk_rise |=> st_q.store_q == '0;
    endproperty
    a_clear_latch_blocked: assert property (p_clear_latch_blocked) else $error("latch during clear"); // [RULE_13]

    property p_clear_release;
        $rose(clr_n) |-> st_q.shift_q == '0 && st_q.store_q == '0 && sink_channel_oe_o == '0;
    endproperty
    a_clear_release: assert property (p_clear_release) else $error("clear not held to release"); // [RULE_13]

    property p_sink_off_zero;
        clr_n && !oe_n && st_q.store_q == '0 |=> sink_channel_oe_o == '0;
    endproperty
    a_sink_off_zero: assert property (p_sink_off_zero) else $error("sink on for zero bit"); // [RULE_11]

    property p_enable_on;
        $fell(oe_n) && clr_n |=> sink_channel_oe_o == $past(st_q.store_q);
    endproperty
    a_enable_on: assert property (p_enable_on) else $error("sinks late after enable"); // [RULE_07]
endmodule

/* ssld_pkg_note_unused.sv */
// intentionally empty

/* ssld_host.sv */
// host model driving the serial pins of the shift latch driver
`timescale 1ns/1ps
module ssld_host
    import ssld_pkg::*;
#(
    parameter int unsigned HOLD = 6
) (
    // clock
    input  wire logic clk_i,
    // pins towards the device
    output logic      shift_clock_o,
    output logic      latch_clock_o,
    output logic      shift_data_o,
    output logic      clear_n_o,
    output logic      output_enable_n_o
);
    initial begin
        {shift_clock_o, latch_clock_o, shift_data_o} = 3'h0;
        {clear_n_o, output_enable_n_o} = 2'h3;
    end
    // every level lasts HOLD cycles so the device filter sees it
    task automatic hold_pins(input int unsigned n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic shift_rise(input logic b);
        shift_data_o = b;
        hold_pins(HOLD);
        shift_clock_o = 1'h1;
        hold_pins(HOLD);
    endtask
    // data hold has run out after the fall, so stop showing the old bit
    task automatic shift_fall();
        shift_clock_o = 1'h0;
        shift_data_o  = ~shift_data_o;
        hold_pins(HOLD);
    endtask
    task automatic pulse_latch();
        latch_clock_o = 1'h1;
        hold_pins(HOLD);
        latch_clock_o = 1'h0;
        hold_pins(HOLD);
    endtask
    task automatic set_pins(input logic clr_n, input logic oe_n);
        clear_n_o         = clr_n;
        output_enable_n_o = oe_n;
        hold_pins(HOLD);
    endtask
endmodule

/* ssld_test.sv */
// self-checking bench for the serial shift latch driver
`timescale 1ns/1ps
module ssld_test;
    import ssld_pkg::*;
    logic       clk_i, rst_i, sclk, lclk, sdat, clr_n, oe_n, casc;
    ssld_word_t sink, sink_oe;
    int         n_errors = 0;
    int         n_tests  = 0;

    ssld_top ssld_top_i (.clk_i(clk_i), .rst_i(rst_i), .shift_clock_i(sclk),
        .latch_clock_i(lclk), .shift_data_in_i(sdat), .clear_n_i(clr_n),
        .output_enable_n_i(oe_n), .cascade_data_out_o(casc),
        .sink_channel_o(sink), .sink_channel_oe_o(sink_oe));
    ssld_host ssld_host_i (.clk_i(clk_i), .shift_clock_o(sclk), .latch_clock_o(lclk),
        .shift_data_o(sdat), .clear_n_o(clr_n), .output_enable_n_o(oe_n));

    task automatic check(input ssld_word_t got, input ssld_word_t exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors=%0d checks=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic bit_in(input logic b);
        ssld_host_i.shift_rise(b);
        ssld_host_i.shift_fall();
    endtask

    task automatic test_load();
        ssld_word_t pat;
        pat = 12'ha5c;
        // most significant bit first, so it ends up in the last stage
        for (int i = 11; i >= 0; i--)
            bit_in(pat[i]);
        check(sink_oe, 12'h000);
        ssld_host_i.pulse_latch();
        check(sink_oe, 12'ha5c);
        check(sink, 12'h000);
        $display("test load done");
    endtask
    task automatic test_cascade();
        check({11'h0, casc}, 12'h001);
        ssld_host_i.shift_rise(1'h1);
        check({11'h0, casc}, 12'h001);
        ssld_host_i.shift_fall();
        check({11'h0, casc}, 12'h000);
        check(sink_oe, 12'ha5c);
        ssld_host_i.pulse_latch();
        check(sink_oe, 12'h4b9);
        $display("test cascade done");
    endtask
    task automatic test_enable();
        ssld_host_i.set_pins(1'h1, 1'h1);
        check(sink_oe, 12'h000);
        ssld_host_i.set_pins(1'h1, 1'h0);
        check(sink_oe, 12'h4b9);
        $display("test enable done");
    endtask
    task automatic test_clear();
        // put a one on the cascade output first, so that the clear has something to empty
        bit_in(1'h1);
        check({11'h0, casc}, 12'h001);
        check(sink_oe, 12'h4b9);
        ssld_host_i.set_pins(1'h0, 1'h0);
        check(sink_oe, 12'h000);
        check({11'h0, casc}, 12'h000);
        bit_in(1'h1);
        ssld_host_i.pulse_latch();
        check(sink_oe, 12'h000);
        ssld_host_i.set_pins(1'h1, 1'h0);
        ssld_host_i.pulse_latch();
        check(sink_oe, 12'h000);
        $display("test clear done");
    endtask

    initial begin
        clk_i = 1'h0;
        forever #12.5 clk_i = ~clk_i;
    end
    // guard against a hung sequence
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        stop_test();
    end
    initial begin
        rst_i = 1'h1;
        ssld_host_i.hold_pins(5);
        rst_i = 1'h0;
        ssld_host_i.set_pins(1'h1, 1'h0);
        test_load();
        test_cascade();
        test_enable();
        test_clear();
        stop_test();
    end
endmodule
